// ===== verilog/asrr_pkg.sv
// asrr_pkg: constants and carrier types for the serial result readout
// assumes a 200 MHz core clock; link clock arrives on the shift strobe pin
package asrr_pkg;
  // ****************************************
  // widths and timing
  // ****************************************
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned CORE_PERIOD_PS = 5000;
  // conversion time, ns
  localparam int unsigned CONVERSION_TRIGGER_N_TIME_NS = 12000;
  localparam int unsigned CONVERSION_TRIGGER_N_CYC = (CONVERSION_TRIGGER_N_TIME_NS * 1000) / CORE_PERIOD_PS;
  // conversion low to first internal strobe, ns
  localparam int unsigned FIRST_STROBE_NS = 2000;
  localparam int unsigned FIRST_STROBE_CYC = (FIRST_STROBE_NS * 1000) / CORE_PERIOD_PS;
  // internal strobe half period, ns (least 300 ns)
  localparam int unsigned HALF_PERIOD_NS = 355;
  localparam int unsigned HALF_CYC = (HALF_PERIOD_NS * 1000 + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;

  typedef enum logic [1:0] {ASRR_IDLE, ASRR_CONVERSION_TRIGGER_N} asrr_conversion_trigger_n_state_t;

  // pin group for the shift strobe and data
  typedef struct packed {
    logic strobe_out;
    logic strobe_oe;
    logic data_out;
    logic data_oe;
  } asrr_pins_t;
endpackage : asrr_pkg

// ===== verilog/asrr_readout.sv
// asrr_readout: serial result readout of a 12-bit sampling converter
// assumes core_clk at 200 MHz, the sampler supplies only a result; conversion end is counted internally
//
// Operation
// - internal mode: shift previous result during the next conversion, own clock
// - internal mode: transmit only while a conversion runs
// - internal mode: data and strobe low when not transmitting
// - 12-bit twos complement, most significant bit first
// - internal mode: data stable across strobe rising edge, changes with falling edge
// - internal mode: busy low through the whole transfer
// - external mode: shifting starts on a host strobe rising edge
// - external mode: bit valid at strobe falling edge
// - external mode: strobe high and selected at busy rise: keep old contents
// - shift register loads only at conversion end
// - deselect disables outputs and gates external strobe
// - outputs disable via chip select at any time
// - conversion starts on trigger falling edge regardless of select
// - internal mode deselected whole conversion: transfer runs unseen
// - strobe pin driven only in internal mode
// - trigger edges ignored while converting
`timescale 1ns/1ps
`default_nettype none
module asrr_readout (
  // clocks and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  // pins from the host
  input wire logic conversion_trigger_n,
  input wire logic chip_select_n,
  input wire logic shift_clock_source_select,
  // converter core
  input wire logic [asrr_pkg::RESULT_W-1:0] conversion_trigger_n_result,
  // pins to the host
  output logic busy,
  output asrr_pkg::asrr_pins_t pins
);
  // ****************************************
  // core domain state
  // ****************************************
  typedef struct packed {
    logic [1:0] trig_s;
    logic trig_d;
    logic [1:0] cs_s;
    logic [1:0] sel_s;
    logic [1:0] lnk_s;
    asrr_pkg::asrr_conversion_trigger_n_state_t st;
    logic [15:0] cnt;
    logic [asrr_pkg::RESULT_W-1:0] shreg;
    logic [3:0] bits;
    logic [7:0] hcnt;
    logic sclk;
    logic xmit;
    logic busy;
    logic [4:0] gray_s1;
    logic [4:0] gray_s2;
    logic [4:0] ext_base;
    asrr_pkg::asrr_pins_t pins;
  } asrr_core_t;

  asrr_core_t r;
  asrr_core_t next_r;

  // link domain: gated host strobe rises, gray coded for the crossing
  typedef struct packed {
    logic [4:0] rise_cnt;
    logic [4:0] rise_gray;
  } asrr_link_t;

  asrr_link_t l;
  asrr_link_t next_l;

  always_comb begin
    logic trig_fall;
    logic ext_mode;
    logic cs_act;
    logic block_load;
    logic [4:0] rise_bin;
    logic [4:0] ext_idx;
    logic [4:0] ext_shift;
    logic [asrr_pkg::RESULT_W-1:0] ext_word;
    trig_fall = 1'b0;
    ext_mode = 1'b0;
    cs_act = 1'b0;
    block_load = 1'b0;
    rise_bin = '0;
    ext_idx = '0;
    ext_shift = '0;
    ext_word = '0;
    next_r = r;
    next_r.trig_s = {r.trig_s[0], conversion_trigger_n};
    next_r.cs_s = {r.cs_s[0], chip_select_n};
    next_r.sel_s = {r.sel_s[0], shift_clock_source_select};
    next_r.lnk_s = {r.lnk_s[0], link_clk};
    next_r.gray_s1 = l.rise_gray;
    next_r.gray_s2 = r.gray_s1;
    rise_bin[4] = r.gray_s2[4];
    for (int i = 3; i >= 0; i--) begin
      rise_bin[i] = rise_bin[i + 1] ^ r.gray_s2[i];
    end
    next_r.trig_d = r.trig_s[1];
    trig_fall = r.trig_d & ~r.trig_s[1];
    ext_mode = r.sel_s[1];
    cs_act = ~r.cs_s[1];
    case (r.st)
      asrr_pkg::ASRR_IDLE: begin
        if (trig_fall) begin
          next_r.st = asrr_pkg::ASRR_CONVERSION_TRIGGER_N;
          next_r.cnt = '0;
          next_r.busy = 1'b0;
          next_r.bits = '0;
          next_r.hcnt = '0;
        end
      end
      asrr_pkg::ASRR_CONVERSION_TRIGGER_N: begin
        next_r.cnt = r.cnt + 16'h0001;
        if (!ext_mode && r.cnt == 16'(asrr_pkg::FIRST_STROBE_CYC)) begin
          next_r.xmit = 1'b1;
        end
        if (r.xmit) begin
          if (r.hcnt == 8'(asrr_pkg::HALF_CYC - 1)) begin
            next_r.hcnt = '0;
            next_r.sclk = ~r.sclk;
            // data changes only after falling edge
            if (r.sclk) begin
              next_r.shreg = {r.shreg[asrr_pkg::RESULT_W-2:0], 1'b0};
              next_r.bits = r.bits + 4'h1;
              if (r.bits == 4'(asrr_pkg::RESULT_W - 1)) begin
                next_r.xmit = 1'b0;
              end
            end
          end else begin
            next_r.hcnt = r.hcnt + 8'h01;
          end
        end
        if (r.cnt == 16'(asrr_pkg::CONVERSION_TRIGGER_N_CYC - 1)) begin
          next_r.st = asrr_pkg::ASRR_IDLE;
          next_r.busy = 1'b1;
          next_r.xmit = 1'b0;
          next_r.sclk = 1'b0;
          // strobe high and selected in external mode blocks load
          block_load = ext_mode & cs_act & r.lnk_s[1];
          if (!block_load) begin
            next_r.shreg = conversion_trigger_n_result;
            next_r.ext_base = rise_bin;
          end
        end
      end
      default: next_r.st = asrr_pkg::ASRR_IDLE;
    endcase
    // strobe pin output only in internal mode
    next_r.pins.strobe_oe = ~ext_mode & cs_act;
    next_r.pins.data_oe = cs_act;
    next_r.pins.strobe_out = ~ext_mode & next_r.sclk & next_r.xmit;
    // first rise shows msb, later rises advance
    ext_idx = rise_bin - next_r.ext_base;
    ext_shift = (ext_idx == 5'h00) ? 5'h00 : ext_idx - 5'h01;
    ext_word = next_r.shreg << ext_shift;
    if (ext_mode) begin
      next_r.pins.data_out = ext_word[asrr_pkg::RESULT_W-1];
    end else begin
      next_r.pins.data_out = next_r.xmit & next_r.shreg[asrr_pkg::RESULT_W-1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      r <= '0;
      r.busy <= 1'b1;
      r.trig_d <= 1'b1;
      r.trig_s <= 2'h3;
      r.cs_s <= 2'h3;
      r.shreg <= asrr_pkg::RESULT_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign busy = r.busy;
  assign pins = r.pins;

  // ****************************************
  // link domain shifting
  // ****************************************
  always_comb begin
    next_l = l;
    if (!chip_select_n && shift_clock_source_select) begin
      next_l.rise_cnt = l.rise_cnt + 5'h01;
    end
    next_l.rise_gray = next_l.rise_cnt ^ (next_l.rise_cnt >> 1);
  end

  always_ff @(posedge link_clk) begin
    if (!rst_b) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence conversion_trigger_n_start_s;
    r.st == asrr_pkg::ASRR_IDLE && r.trig_d && !r.trig_s[1];
  endsequence

  sequence conversion_trigger_n_end_s;
    r.st == asrr_pkg::ASRR_CONVERSION_TRIGGER_N && r.cnt == 16'(asrr_pkg::CONVERSION_TRIGGER_N_CYC - 1);
  endsequence

  sequence load_block_s;
    conversion_trigger_n_end_s ##0 (r.sel_s[1] && !r.cs_s[1] && r.lnk_s[1]);
  endsequence

  sequence load_ok_s;
    conversion_trigger_n_end_s ##0 !(r.sel_s[1] && !r.cs_s[1] && r.lnk_s[1]);
  endsequence

  sequence int_first_s;
    r.st == asrr_pkg::ASRR_CONVERSION_TRIGGER_N && !r.sel_s[1] && r.cnt == 16'(asrr_pkg::FIRST_STROBE_CYC);
  endsequence

  start_busy_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    conversion_trigger_n_start_s |=> !r.busy) else $error("conversion start did not drop busy");

  idle_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !r.xmit && !r.sel_s[1] |=> !pins.strobe_out) else $error("strobe active while idle");

  xmit_busy_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.xmit |-> !r.busy) else $error("busy high during transfer");

  xmit_conversion_trigger_n_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.xmit |-> r.st == asrr_pkg::ASRR_CONVERSION_TRIGGER_N) else $error("transfer outside conversion");

  ext_pin_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.sel_s[1] |=> !pins.strobe_oe) else $error("strobe driven in external mode");

  desel_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.cs_s[1] |=> !pins.data_oe) else $error("data driven while deselected");

  bit_count_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.bits <= 4'(asrr_pkg::RESULT_W)) else $error("more than twelve bits");

  stable_data_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.xmit && !r.sclk && next_r.sclk |=> $stable(r.shreg)) else $error("data moved at strobe rise");

  ignore_trig_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.st == asrr_pkg::ASRR_CONVERSION_TRIGGER_N && r.cnt != 16'(asrr_pkg::CONVERSION_TRIGGER_N_CYC - 1) |=> r.st == asrr_pkg::ASRR_CONVERSION_TRIGGER_N)
    else $error("conversion aborted early");

  start_conversion_trigger_n_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    conversion_trigger_n_start_s |=> r.st == asrr_pkg::ASRR_CONVERSION_TRIGGER_N) else $error("trigger edge did not start conversion");

  busy_end_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    conversion_trigger_n_end_s |=> r.busy) else $error("busy not raised at conversion end");

  load_take_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    load_ok_s |=> r.shreg == $past(conversion_trigger_n_result)) else $error("result not loaded at conversion end");

  load_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    load_block_s |=> $stable(r.shreg)) else $error("blocked load changed the word");

  idle_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.st == asrr_pkg::ASRR_IDLE |=> $stable(r.shreg)) else $error("word changed while idle");

  idle_low_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.st == asrr_pkg::ASRR_IDLE && !r.sel_s[1] |=> !pins.data_out && !pins.strobe_out)
    else $error("pins not low between conversions");

  xmit_start_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    int_first_s |=> r.xmit) else $error("internal frame did not start");

  first_msb_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    int_first_s |=> pins.data_out == r.shreg[asrr_pkg::RESULT_W-1]) else $error("frame did not lead with msb");

  strobe_oe_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !r.sel_s[1] && !r.cs_s[1] |=> pins.strobe_oe) else $error("strobe not driven in internal mode");

  sel_data_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !r.cs_s[1] |=> pins.data_oe) else $error("data not driven while selected");

  ext_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.sel_s[1] |=> !pins.strobe_out) else $error("strobe toggled in external mode");

  last_bit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.xmit && r.sclk && r.hcnt == 8'(asrr_pkg::HALF_CYC - 1) && r.bits == 4'(asrr_pkg::RESULT_W - 1)
    |=> !r.xmit && !pins.strobe_out) else $error("frame did not end after last bit");

  half_len_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.hcnt <= 8'(asrr_pkg::HALF_CYC - 1)) else $error("half period counter overran");

  strobe_busy_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    pins.strobe_out |-> !r.busy) else $error("strobe high while busy high");

  desel_run_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    int_first_s ##0 r.cs_s[1] |=> r.xmit) else $error("deselected frame did not run");

  sclk_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !r.xmit |-> !r.sclk) else $error("strobe high outside frame");

  ext_msb_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    load_ok_s ##0 r.sel_s[1] |=> pins.data_out == r.shreg[asrr_pkg::RESULT_W-1]) else $error("external msb missing");

  cnt_range_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.st == asrr_pkg::ASRR_CONVERSION_TRIGGER_N |-> r.cnt < 16'(asrr_pkg::CONVERSION_TRIGGER_N_CYC)) else $error("conversion counter overran");

  busy_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.st == asrr_pkg::ASRR_IDLE |-> r.busy) else $error("busy low while idle");

  shift_msb_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    r.xmit && r.sclk && r.hcnt == 8'(asrr_pkg::HALF_CYC - 1) |=> r.shreg == ($past(r.shreg) << 1))
    else $error("word not shifted msb first");
endmodule : asrr_readout
`default_nettype wire

// ===== sim/asrr_host.sv
// asrr_host: host model that reads serial results
// assumes the bench calls its tasks; link clock idles low
`timescale 1ns/1ps
`default_nettype none
module asrr_host (
  // link side
  output logic link_clk,
  input wire asrr_pkg::asrr_pins_t pins
);
  // ****************************************
  // capture of frames
  // ****************************************
  logic [11:0] int_word;
  int int_cnt;
  initial begin
    link_clk = 1'b0;
    int_word = 12'h000;
    int_cnt = 0;
  end
  always @(posedge pins.strobe_out) if (pins.strobe_oe === 1'b1) begin
    int_word = {int_word[10:0], pins.data_out};
    int_cnt++;
  end
  // fall sampling, 48 ns period, ends low
  task automatic read_ext(output logic [11:0] w);
    for (int i = 0; i < 12; i++) begin
      #24 link_clk = 1'b1;
      #24 w = {w[10:0], pins.data_out};
      link_clk = 1'b0;
    end
  endtask : read_ext
  task automatic set_clk(input logic v);
    link_clk = v;
  endtask : set_clk
endmodule : asrr_host
`default_nettype wire

// ===== sim/asrr_readout_bench.sv
// asrr_readout_bench: self-checking bench for the readout
// assumes asrr_host drives the link clock
`timescale 1ns/1ps
`default_nettype none
module asrr_readout_bench;
  logic core_clk;
  logic rst_b;
  logic link_clk;
  logic conversion_trigger_n;
  logic chip_select_n;
  logic shift_clock_source_select;
  logic [11:0] conversion_trigger_n_result;
  logic busy;
  asrr_pkg::asrr_pins_t pins;
  logic [11:0] w;
  logic [7:0] cs_h;
  logic [7:0] sel_h;
  int err_total;
  int n_tests;
  int viol;
  asrr_readout dut_u (.core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk),
    .conversion_trigger_n(conversion_trigger_n), .chip_select_n(chip_select_n),
    .shift_clock_source_select(shift_clock_source_select), .conversion_trigger_n_result(conversion_trigger_n_result),
    .busy(busy), .pins(pins));
  asrr_host host_u (.link_clk(link_clk), .pins(pins));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ****************************************
  // checks and monitors
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  always @(posedge core_clk) begin
    cs_h <= {cs_h[6:0], chip_select_n};
    sel_h <= {sel_h[6:0], shift_clock_source_select};
    if (~|sel_h && busy === 1'b1 && {pins.strobe_out, pins.data_out} !== 2'b00) viol++;
    if (&cs_h && {pins.strobe_oe, pins.data_oe} !== 2'b00) viol++;
    // strobe pin input in external mode
    if (&sel_h && pins.strobe_oe !== 1'b0) viol++;
  end
  // one conversion, retrigger mid-way, busy length measured
  task automatic run_conversion_trigger_n(input logic [11:0] r);
    int n;
    n = 0;
    conversion_trigger_n_result <= r;
    conversion_trigger_n <= 1'b0;
    @(posedge core_clk);
    while (busy !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    while (busy === 1'b0 && n < 3000) begin
      @(posedge core_clk);
      n++;
      conversion_trigger_n <= !((n < 10) || (n > 900 && n < 920));
    end
    check(n, asrr_pkg::CONVERSION_TRIGGER_N_CYC);
    repeat (2600) @(posedge core_clk);
  endtask : run_conversion_trigger_n
  // ****************************************
  // tests
  // ****************************************
  initial begin
    rst_b = 1'b0;
    conversion_trigger_n = 1'b1;
    chip_select_n = 1'b0;
    shift_clock_source_select = 1'b0;
    conversion_trigger_n_result = 12'h000;
    cs_h = 8'h00;
    sel_h = 8'h00;
    err_total = 0;
    n_tests = 0;
    viol = 0;
    host_u.read_ext(w);
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
    run_conversion_trigger_n(12'h7ff);
    check(host_u.int_word, asrr_pkg::RESULT_RESET);
    run_conversion_trigger_n(12'h800);
    check(host_u.int_word, 12'h7ff);
    check(host_u.int_cnt, 24);
    $display("test internal done");
    shift_clock_source_select <= 1'b1;
    repeat (10) @(posedge core_clk);
    host_u.read_ext(w);
    check(w, 12'h800);
    @(posedge core_clk);
    run_conversion_trigger_n(12'h5a3);
    fork
      run_conversion_trigger_n(12'h0f0);
      begin
        repeat (20) @(posedge core_clk);
        host_u.read_ext(w);
      end
    join
    check(w, 12'h5a3);
    $display("test external done");
    chip_select_n <= 1'b1;
    @(posedge core_clk);
    host_u.set_clk(1'b1);
    repeat (8) @(posedge core_clk);
    chip_select_n <= 1'b0;
    run_conversion_trigger_n(12'h123);
    host_u.set_clk(1'b0);
    host_u.read_ext(w);
    check(w, 12'h0f0);
    $display("test strobe high at load done");
    @(posedge core_clk);
    chip_select_n <= 1'b1;
    shift_clock_source_select <= 1'b0;
    repeat (10) @(posedge core_clk);
    host_u.int_cnt = 0;
    run_conversion_trigger_n(12'h456);
    check(host_u.int_cnt, 0);
    check(viol, 0);
    $display("test deselect done");
    finish_test();
  end
  initial begin
    repeat (80000) @(posedge core_clk);
    err_total++;
    finish_test();
  end
endmodule : asrr_readout_bench
`default_nettype wire
